// [pkg/gate_pkg.sv]
// gate_pkg: constants and types for the input gate and delay section
// assumes a 50 kHz sample strobe on the 25 MHz bus clock
package gate_pkg;

  localparam int SW       = 24;
  localparam int N_OUT    = 2;
  localparam int CLK_NS   = 40;
  localparam int SMP_NS   = 20000;
  localparam int LAT_NS   = 1665000;
  localparam int LAT_SMP  = LAT_NS / SMP_NS;
  localparam int LOOK_MAX = 10000000 / SMP_NS;
  localparam int ALN_MAX  = 2000000000 / SMP_NS;
  localparam int AW       = 17;
  localparam int MEM_D    = 1 << AW;
  localparam int SMP_10MS = 10000000 / SMP_NS;
  localparam int SMP_01MS = 100000 / SMP_NS;
  localparam int RAMP_HDB = 40;
  localparam int FRAC     = 20;
  localparam int FLOOR_HDB = 200;

  // register byte offsets
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_DEPTH = 8'h04;
  localparam logic [7:0] A_THR   = 8'h08;
  localparam logic [7:0] A_HYST  = 8'h0C;
  localparam logic [7:0] A_LOOK  = 8'h10;
  localparam logic [7:0] A_ALIGN = 8'h14;
  localparam logic [7:0] A_ATK   = 8'h18;
  localparam logic [7:0] A_HOLD  = 8'h1C;
  localparam logic [7:0] A_REL   = 8'h20;
  localparam logic [7:0] A_FADER = 8'h24;
  localparam logic [7:0] A_MIX0  = 8'h28;
  localparam logic [7:0] A_MIX1  = 8'h2C;
  localparam logic [7:0] A_STAT  = 8'h30;
  localparam logic [7:0] A_METER = 8'h34;

  // control and status register bit positions
  localparam int C_GATE = 0;
  localparam int C_SRC  = 1;
  localparam int C_MUTE = 2;
  localparam int C_INV  = 3;
  localparam int C_SC   = 4;
  localparam int C_SH   = 8;
  localparam int S_ATT  = 8;

  typedef logic signed [SW-1:0] sample_t;
  typedef logic [N_OUT-1:0][SW-1:0] mix_t;
  typedef enum logic [1:0] {G_CLOSED, G_OPEN, G_HOLD} gate_st_t;

  typedef struct packed {
    logic                   gate_en;
    logic                   src_net;
    logic                   mute;
    logic                   inv;
    logic                   sc_en;
    logic [3:0]             sc_sh;
    logic [7:0]             depth;
    logic signed [8:0]      thr;
    logic [4:0]             hyst;
    logic [8:0]             look;
    logic [AW-1:0]          align;
    logic [9:0]             atk;
    logic [9:0]             hold;
    logic [9:0]             rel;
    logic [7:0]             fader;
    logic [N_OUT-1:0][7:0]  mix;
  } cfg_t;

  localparam cfg_t CFG_RST = '{
    gate_en: 1'b0, src_net: 1'b0, mute: 1'b0, inv: 1'b0,
    sc_en: 1'b0, sc_sh: 4'h4, depth: 8'hC8, thr: -9'sd120,
    hyst: 5'h04, look: 9'h000, align: 17'h00000,
    atk: 10'h00A, hold: 10'h00A, rel: 10'h00A,
    fader: 8'h00, mix: {N_OUT{8'h00}}};

endpackage : gate_pkg

// [verilog/audio_input_gate_delay.sv]
// audio_input_gate_delay: one input section with source select, delay,
// noise gate, fader/mute/invert and a small mix matrix
// assumes sample_valid is a one-cycle strobe from same-clock logic
`timescale 1ns/100ps

module audio_input_gate_delay
  import gate_pkg::*;
(
  // system
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // audio sources
  input  wire sample_t     analog_in,
  input  wire sample_t     net_in,
  input  wire logic        sample_valid,
  // to the mixing matrix
  output mix_t             mix_out,
  output logic             mix_valid
);

  typedef struct packed {
    cfg_t            cfg;
    logic [31:0]     rdata;
    logic            rdy;
    logic            wr_pend;
    logic [7:0]      wr_addr;
    logic [AW-1:0]   wp;
    logic [22:0]     meter;
    gate_st_t        st;
    logic [18:0]     hold;
    logic [27:0]     att;
    sample_t         lp;
    logic [1:0]      ph;
    sample_t         y;
    mix_t            mix;
    logic            mv;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  // delay line, sized for the 2 s maximum
  sample_t         mem [MEM_D];
  sample_t         rd_q;
  logic [AW-1:0]   rd_addr;
  sample_t         src;

  // half-dB attenuation to Q16 gain; 6 dB taken as one octave, which
  // costs about 0.02 dB per 6 dB but avoids a real exponent
  function automatic logic [16:0] db2lin(input logic [9:0] a);
    logic [16:0] t;
    logic [9:0]  q;
    q = a / 10'd12;
    case (a % 10'd12)
      10'd0:   t = 17'h10000;
      10'd1:   t = 17'h0F1AE;
      10'd2:   t = 17'h0E429;
      10'd3:   t = 17'h0D766;
      10'd4:   t = 17'h0CB59;
      10'd5:   t = 17'h0BFF9;
      10'd6:   t = 17'h0B53C;
      10'd7:   t = 17'h0AB19;
      10'd8:   t = 17'h0A186;
      10'd9:   t = 17'h0987D;
      10'd10:  t = 17'h08FF6;
      default: t = 17'h087E8;
    endcase
    if (a >= 10'(FLOOR_HDB)) t = 17'h00000;
    else t = t >> q;
    return t;
  endfunction : db2lin

  // magnitude level of a signed half-dB figure; at or above full scale the
  // level is pinned at 7FFFFF, which a negative full-scale sample still exceeds
  function automatic logic [22:0] level(input logic signed [9:0] t);
    logic [23:0] v;
    v = {db2lin(10'(-t)), 7'h00};
    if (t >= 0) return 23'h7FFFFF;
    return v[22:0];
  endfunction : level

  // per-sample step so that 20 dB takes n samples
  function automatic logic [27:0] ramp_step(input logic [19:0] n);
    logic [27:0] num;
    num = 28'(RAMP_HDB) << FRAC;
    return (n == 20'h00000) ? num : num / 28'(n);
  endfunction : ramp_step

  function automatic sample_t scale(input sample_t x,
                                    input logic [16:0] g);
    logic signed [41:0] p;
    p = 42'(x) * $signed({1'b0, g});
    return p[39:16];
  endfunction : scale

  function automatic logic [23:0] mag(input logic signed [24:0] x);
    logic [24:0] m;
    m = x[24] ? 25'(-x) : 25'(x);
    return m[24] ? 24'hFFFFFF : m[23:0];
  endfunction : mag

  function automatic logic [31:0] rd_word(input logic [7:0] a,
                                          input state_t s);
    logic [31:0] w;
    w = 32'h00000000;
    case (a)
      A_CTRL: begin
        w[C_GATE] = s.cfg.gate_en;
        w[C_SRC] = s.cfg.src_net;
        w[C_MUTE] = s.cfg.mute;
        w[C_INV] = s.cfg.inv;
        w[C_SC] = s.cfg.sc_en;
        w[C_SH +: 4] = s.cfg.sc_sh;
      end
      A_DEPTH: w[7:0] = s.cfg.depth;
      A_THR:   w = 32'(s.cfg.thr);
      A_HYST:  w[4:0] = s.cfg.hyst;
      A_LOOK:  w[8:0] = s.cfg.look;
      A_ALIGN: w[AW-1:0] = s.cfg.align;
      A_ATK:   w[9:0] = s.cfg.atk;
      A_HOLD:  w[9:0] = s.cfg.hold;
      A_REL:   w[9:0] = s.cfg.rel;
      A_FADER: w[7:0] = s.cfg.fader;
      A_MIX0:  w[7:0] = s.cfg.mix[0];
      A_MIX1:  w[7:0] = s.cfg.mix[1];
      A_STAT: begin
        w[1:0] = s.st;
        w[S_ATT +: 8] = s.att[FRAC +: 8];
      end
      A_METER: w[22:0] = s.meter;
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction : rd_word

  // source select and buffer read address
  always_comb begin
    src = s_r.cfg.src_net ? net_in : analog_in;
    rd_addr = s_r.wp - AW'(LAT_SMP) - s_r.cfg.align
              - AW'(s_r.cfg.look);
  end

  always_comb begin
    logic                ap;
    logic signed [24:0]  diff;
    logic [23:0]         key;
    logic [23:0]         smag;
    logic [22:0]         open_lvl;
    logic [22:0]         close_lvl;
    logic [27:0]         tgt;
    logic [27:0]         up;
    logic [27:0]         dn;
    logic [16:0]         g;
    sample_t             yy;
    s_nxt = s_r;
    ap = hsel & htrans[1] & hready;
    diff = 25'(src) - 25'(s_r.lp);
    key = s_r.cfg.sc_en ? mag(diff) : mag(25'(src));
    smag = mag(25'(src));
    open_lvl = level(10'(s_r.cfg.thr) + 10'(s_r.cfg.hyst));
    close_lvl = level(10'(s_r.cfg.thr) - 10'(s_r.cfg.hyst));
    tgt = (s_r.st == G_CLOSED) ? 28'(s_r.cfg.depth) << FRAC : 28'h0;
    up = ramp_step(20'(s_r.cfg.rel) * 20'(SMP_10MS));
    dn = ramp_step(20'(s_r.cfg.atk) * 20'(SMP_01MS));
    g = 17'h00000;
    yy = s_r.y;
    s_nxt.mv = 1'b0;
    s_nxt.rdy = 1'b1;

    // bus: write lands in the data phase, reads see it at once
    if (s_r.wr_pend) begin
      case (s_r.wr_addr)
        A_CTRL: begin
          s_nxt.cfg.gate_en = hwdata[C_GATE];
          s_nxt.cfg.src_net = hwdata[C_SRC];
          s_nxt.cfg.mute = hwdata[C_MUTE];
          s_nxt.cfg.inv = hwdata[C_INV];
          s_nxt.cfg.sc_en = hwdata[C_SC];
          s_nxt.cfg.sc_sh = hwdata[C_SH +: 4];
        end
        A_DEPTH: s_nxt.cfg.depth = (hwdata[7:0] > 8'(FLOOR_HDB)) ?
                                   8'(FLOOR_HDB) : hwdata[7:0];
        A_THR:   s_nxt.cfg.thr = hwdata[8:0];
        A_HYST:  s_nxt.cfg.hyst = (hwdata[4:0] > 5'h18) ?
                                  5'h18 : hwdata[4:0];
        A_LOOK:  s_nxt.cfg.look = (hwdata[8:0] > 9'(LOOK_MAX)) ?
                                  9'(LOOK_MAX) : hwdata[8:0];
        A_ALIGN: s_nxt.cfg.align = (hwdata[AW-1:0] > AW'(ALN_MAX)) ?
                                   AW'(ALN_MAX) : hwdata[AW-1:0];
        A_ATK:   s_nxt.cfg.atk = hwdata[9:0];
        A_HOLD:  s_nxt.cfg.hold = hwdata[9:0];
        A_REL:   s_nxt.cfg.rel = hwdata[9:0];
        A_FADER: s_nxt.cfg.fader = hwdata[7:0];
        A_MIX0:  s_nxt.cfg.mix[0] = hwdata[7:0];
        A_MIX1:  s_nxt.cfg.mix[1] = hwdata[7:0];
        default: s_nxt.cfg = s_nxt.cfg;
      endcase
    end
    s_nxt.wr_pend = ap & hwrite;
    s_nxt.wr_addr = haddr[7:0];
    if (ap && !hwrite) begin
      s_nxt.rdata = rd_word(haddr[7:0], s_nxt);
      if (haddr[7:0] == A_METER) s_nxt.meter = 23'h000000;
    end

    // a new peak beats a clear by read in the same cycle
    // compare all 24 bits so a full-scale peak still saturates the meter
    if (sample_valid && smag > 24'(s_nxt.meter)) begin
      s_nxt.meter = smag[23] ? 23'h7FFFFF : smag[22:0];
    end

    case (s_r.ph)
      2'd0: begin
        if (sample_valid) begin
          s_nxt.wp = s_r.wp + 1'b1;
          s_nxt.lp = s_r.lp + SW'(diff >>> s_r.cfg.sc_sh);
          s_nxt.ph = 2'd1;
          case (s_r.st)
            G_CLOSED: if (key > 24'(open_lvl)) s_nxt.st = G_OPEN;
            G_OPEN: begin
              if (key < 24'(close_lvl)) begin
                s_nxt.st = G_HOLD;
                s_nxt.hold = 19'(s_r.cfg.hold) * 19'(SMP_10MS);
              end
            end
            G_HOLD: begin
              if (key > 24'(open_lvl)) s_nxt.st = G_OPEN;
              else if (s_r.hold == 19'h00000)
                s_nxt.st = G_CLOSED;
              else s_nxt.hold = s_r.hold - 1'b1;
            end
            default: s_nxt.st = G_CLOSED;
          endcase
          // ramp toward open (0) or depth at a fixed dB rate
          if (s_r.att < tgt) begin
            s_nxt.att = (tgt - s_r.att > up) ? s_r.att + up : tgt;
          end else begin
            s_nxt.att = (s_r.att - tgt > dn) ? s_r.att - dn : tgt;
          end
          if (!s_r.cfg.gate_en) begin
            s_nxt.st = G_CLOSED;
            s_nxt.att = 28'h0;
          end
        end
      end
      2'd1: begin
        // open gate and 0 dB fader give an exact Q16 unity
        g = db2lin(10'(s_r.att[FRAC +: 8]) +
                   10'(s_r.cfg.fader));
        s_nxt.y = scale(rd_q, g);
        s_nxt.ph = 2'd2;
      end
      2'd2: begin
        if (s_r.cfg.mute) yy = '0;
        else if (s_r.cfg.inv)
          yy = (s_r.y == {1'b1, {SW-1{1'b0}}}) ?
               {1'b0, {SW-1{1'b1}}} : -s_r.y;
        for (int i = 0; i < N_OUT; i++) begin
          s_nxt.mix[i] = scale(yy, db2lin(10'(s_r.cfg.mix[i])));
        end
        s_nxt.mv = 1'b1;
        s_nxt.ph = 2'd0;
      end
      default: s_nxt.ph = 2'd0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '{cfg: CFG_RST, st: G_CLOSED, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // key path never reads the buffer, so look-ahead leaves it undelayed
  always_ff @(posedge hclk) begin
    if (sample_valid && s_r.ph == 2'd0) begin
      mem[s_r.wp] <= src;
      rd_q <= mem[rd_addr];
    end
  end

  assign hrdata = s_r.rdata;
  assign hreadyout = s_r.rdy;
  assign hresp = 1'b0;
  assign mix_out = s_r.mix;
  assign mix_valid = s_r.mv;

endmodule : audio_input_gate_delay

// [testbench/sample_source.sv]
// sample_source: paces audio samples into the input section
// assumes the bench sets the analog level; network level is fixed
`timescale 1ns/100ps

module sample_source
  import gate_pkg::*;
(
  // system
  input  wire logic    hclk,
  input  wire logic    hresetn,
  // levels asked for by the bench
  input  wire sample_t amp_a,
  input  wire sample_t amp_n,
  // to the input section
  output sample_t      analog_in,
  output sample_t      net_in,
  output logic         sample_valid
);
  logic [2:0] cnt_r;

  // five clocks apart; between strobes the lines show the inverse
  // so a late capture cannot pass by luck
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r        <= 3'h0;
      sample_valid <= 1'b0;
      analog_in    <= '0;
      net_in       <= '0;
    end else begin
      cnt_r        <= (cnt_r == 3'h4) ? 3'h0 : cnt_r + 3'h1;
      sample_valid <= (cnt_r == 3'h4);
      analog_in    <= (cnt_r == 3'h4) ? amp_a : ~amp_a;
      net_in       <= (cnt_r == 3'h4) ? amp_n : ~amp_n;
    end
  end
endmodule : sample_source

// [testbench/audio_input_gate_delay_monitor.sv]
// audio_input_gate_delay_monitor: port-level checks of the input section
// assumes a single clock domain and a bind onto the top module
`timescale 1ns/100ps

module audio_input_gate_delay_monitor
  import gate_pkg::*;
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // audio
  input wire logic        sample_valid,
  input wire mix_t        mix_out,
  input wire logic        mix_valid
);
  logic rd_go;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  assign rd_go = hsel && htrans[1] && hready && !hwrite;

  resp_okay_a: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  ready_up_a: assert property ($past(hresetn) |-> hreadyout)
    else $error("bus ready low after reset");
  rdata_hold_a: assert property (!$past(rd_go) |-> $stable(hrdata))
    else $error("read data moved without a read");
  unmapped_zero_a: assert property
    (rd_go && haddr[7:0] >= 8'h38 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  mix_latency_a: assert property (sample_valid |-> ##3 mix_valid)
    else $error("mix strobe late");
  mix_cause_a: assert property (mix_valid |-> $past(sample_valid, 3))
    else $error("mix strobe without sample");
  mix_pulse_a: assert property (mix_valid |=> !mix_valid)
    else $error("mix strobe too long");
  mix_hold_a: assert property (!mix_valid |-> $stable(mix_out))
    else $error("mix output moved between strobes");
endmodule : audio_input_gate_delay_monitor

bind audio_input_gate_delay audio_input_gate_delay_monitor i_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .sample_valid(sample_valid),
  .mix_out(mix_out), .mix_valid(mix_valid));

// [testbench/audio_input_gate_delay_bench.sv]
// audio_input_gate_delay_bench: self-checking bench of the input section
// assumes sample_source paces samples five clocks apart
`timescale 1ns/100ps

module audio_input_gate_delay_bench
  import gate_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  sample_t     amp_a;
  sample_t     analog_in;
  sample_t     net_in;
  logic        sample_valid;
  mix_t        mix_out;
  logic        mix_valid;
  int          miscompares;
  int          check_count;
  logic [31:0] q;

  audio_input_gate_delay i_audio_input_gate_delay (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .analog_in(analog_in), .net_in(net_in),
    .sample_valid(sample_valid), .mix_out(mix_out), .mix_valid(mix_valid));

  sample_source i_sample_source (
    .hclk(hclk), .hresetn(hresetn), .amp_a(amp_a), .amp_n(24'h080000),
    .analog_in(analog_in), .net_in(net_in), .sample_valid(sample_valid));

  always #20 hclk = ~hclk;

  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] s);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // one whole-word transfer; hready is sampled at each edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 9);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1 && n++ < 9);
    q = hrdata;
    if (n > 9) begin
      miscompares++;
      stop_test();
    end
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, q);
  endtask : rd

  // returns at the edge where a mix strobe is seen
  task automatic pulses(input int n);
    int k;
    repeat (n) begin
      k = 0;
      do @(posedge hclk); while (mix_valid !== 1'b1 && k++ < 9);
      if (k > 8) begin
        miscompares++;
        stop_test();
      end
    end
  endtask : pulses

  task automatic t_regs;
    logic [7:0]  a [8] = '{A_CTRL, A_DEPTH, A_THR, A_HYST, A_ATK,
                           A_HOLD, A_REL, 8'h38};
    logic [31:0] v [8] = '{32'h400, 32'hC8, 32'hFFFFFF88, 32'h4,
                           32'hA, 32'hA, 32'hA, 32'h0};
    foreach (a[i]) rd(a[i], v[i]);
    wr(A_HYST, 32'h1E);
    rd(A_HYST, 32'h18);
    wr(A_HYST, 32'h4);
  endtask : t_regs

  // counts strobes until a step reaches the output
  task automatic t_lat(input int e);
    int n;
    n = 0;
    amp_a <= 24'h100000;
    do begin
      pulses(1);
      n++;
    end while (mix_out[0] !== 24'h100000 && n < 200);
    chk("latency", e, n);
    chk("mix1", 24'h100000, mix_out[1]);
    amp_a <= 24'h0;
    pulses(e + 5);
  endtask : t_lat

  task automatic t_path;
    logic [31:0] c [6] = '{32'h400, 32'h402, 32'h40A, 32'h406,
                           32'h400, 32'h400};
    logic [7:0]  f [6] = '{0, 0, 0, 0, 12, 0};
    logic [23:0] e0 [6] = '{24'h100000, 24'h080000, 24'hF80000, 24'h0,
                            24'h080000, 24'h100000};
    logic [23:0] e1 [6] = '{24'h100000, 24'h080000, 24'hF80000, 24'h0,
                            24'h020000, 24'h100000};
    for (int i = 0; i < 6; i++) begin
      wr(A_CTRL, c[i]);
      wr(A_FADER, f[i]);
      wr(A_MIX1, 2 * f[i]);
      pulses(95);
      chk("out0", e0[i], mix_out[0]);
      chk("out1", e1[i], mix_out[1]);
    end
  endtask : t_path

  task automatic t_meter;
    bus(1'b0, A_METER, 32'h0);
    pulses(2);
    rd(A_METER, 32'h100000);
    wr(A_CTRL, 32'h402);
    pulses(2);
    bus(1'b0, A_METER, 32'h0);
    pulses(2);
    rd(A_METER, 32'h080000);
    wr(A_CTRL, 32'h400);
  endtask : t_meter

  task automatic lvl(input sample_t a, input int n, input logic [31:0] st);
    amp_a <= a;
    pulses(n);
    rd(A_STAT, st);
  endtask : lvl

  // threshold -20 dB, hysteresis 2 dB, depth 12 dB
  task automatic t_gate;
    wr(A_REL, 32'h1);
    wr(A_HOLD, 32'h1);
    wr(A_ATK, 32'h2);
    wr(A_THR, 32'hFFFFFFD8);
    wr(A_DEPTH, 32'h18);
    amp_a <= 24'h010000;
    wr(A_CTRL, 32'h401);
    pulses(400);
    chk("closed", 24'h004000, mix_out[0]);
    rd(A_STAT, 32'h1800);
    lvl(24'h0F0000, 100, 32'h1800);
    lvl(24'h140000, 120, 32'h0001);
    chk("open", 24'h140000, mix_out[0]);
    lvl(24'h0C0000, 100, 32'h0001);
    lvl(24'h010000, 100, 32'h0002);
    lvl(24'h140000, 5, 32'h0001);
    lvl(24'h010000, 450, 32'h0002);
    pulses(150);
    bus(1'b0, A_STAT, 32'h0);
    chk("state", 32'h0, q & 32'h3);
    wr(A_CTRL, 32'h400);
    pulses(100);
    chk("bypass", 24'h010000, mix_out[0]);
  endtask : t_gate

  initial begin
    hclk        = 1'b0;
    hresetn     = 1'b0;
    hsel        = 1'b0;
    haddr       = 32'h0;
    htrans      = 2'h0;
    hwrite      = 1'b0;
    hwdata      = 32'h0;
    amp_a       = 24'h0;
    miscompares = 0;
    check_count = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    t_regs();
    // fill the delay line with silence before timing anything
    pulses(100);
    t_lat(84);
    wr(A_ALIGN, 32'h3);
    wr(A_LOOK, 32'h2);
    pulses(1);
    t_lat(89);
    wr(A_ALIGN, 32'h0);
    wr(A_LOOK, 32'h0);
    amp_a <= 24'h100000;
    t_path();
    t_meter();
    t_gate();
    stop_test();
  end

  initial begin
    repeat (90000) @(posedge hclk);
    miscompares++;
    stop_test();
  end
endmodule : audio_input_gate_delay_bench
